/* File: logic/itcf_params.svh */
// offsets, bit positions, masks and reset values of the interrupt/trap flag block
`ifndef ITCF_PARAMS_SVH
`define ITCF_PARAMS_SVH

`define ITCF_OFS_CTL_ONE     8'h00
`define ITCF_OFS_CTL_TWO     8'h04
`define ITCF_OFS_FLAGS_ZERO  8'h08
`define ITCF_OFS_STATUS_WORD 8'h0c
`define ITCF_OFS_CORE_WORD   8'h10

`define ITCF_C1_NEST_OFF     15
`define ITCF_C1_ACC_A_OVF    14
`define ITCF_C1_ACC_B_OVF    13
`define ITCF_C1_ACC_A_SEV    12
`define ITCF_C1_ACC_B_SEV    11
`define ITCF_C1_OVA_TRAP_EN  10
`define ITCF_C1_OVB_TRAP_EN  9
`define ITCF_C1_SEV_TRAP_EN  8
`define ITCF_C1_BAD_SHIFT    7
`define ITCF_C1_ZERO_DIV     6
`define ITCF_C1_DMA_FAULT    5
`define ITCF_C1_ARITH_FAULT  4
`define ITCF_C1_ADDR_FAULT   3
`define ITCF_C1_STACK_FAULT  2
`define ITCF_C1_OSC_LOSS     1

`define ITCF_C2_ALT_TABLE    15
`define ITCF_C2_TIMED_DIS    14
`define ITCF_C2_POL_LSB      0
`define ITCF_EXT_LINES       5

`define ITCF_SW_IPL_LSB      5
`define ITCF_CW_IPL_TOP      3

`define ITCF_C1_FLAG_MASK    16'h78fe
`define ITCF_FLAGS_MASK      16'h7fff
`define ITCF_RESET_WORD      16'h0000

`endif

/* File: logic/itcf_pkg.sv */
// types shared by the interrupt/trap flag block
package itcf_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } itcf_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } itcf_wb_rsp_t;

  typedef struct packed {
    logic acc_a_ovf;
    logic acc_b_ovf;
    logic acc_a_sev;
    logic acc_b_sev;
    logic bad_shift;
    logic zero_div;
    logic dma_fault;
    logic addr_fault;
    logic stack_fault;
    logic osc_loss;
  } itcf_trap_evt_t;

  typedef struct packed {
    logic math;
    logic dma;
    logic addr;
    logic stack;
    logic osc;
  } itcf_trap_req_t;

  typedef struct packed {
    logic       ipl_load;
    logic [3:0] ipl_value;
    logic       in_service;
    logic       timed_disable;
  } itcf_core_t;

endpackage

/* File: logic/itcf_sticky.sv */
// sticky flag word: hardware set beats a same-cycle software write
`timescale 1ns/10ps
module itcf_sticky #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] wen_i,
  input  wire logic [W-1:0] wdat_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] flags;
  } itcf_sticky_st_t;

  itcf_sticky_st_t st_q;
  itcf_sticky_st_t st_d;

  always_comb
  begin
    st_d       = st_q;
    st_d.flags = set_i | (wen_i & wdat_i) | (~wen_i & st_q.flags);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q_o = st_q.flags;
endmodule

/* File: logic/itcf_edge.sv */
// two-flop synchroniser and polarity-selected edge detector for one external line
`timescale 1ns/10ps
module itcf_edge (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic line_i,
  input  wire logic falling_i,
  output logic      pulse_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } itcf_edge_st_t;

  itcf_edge_st_t st_q;
  itcf_edge_st_t st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = line_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // only synchronised stages feed the compare
  assign pulse_o = falling_i ? (st_q.s3 & ~st_q.s2) : (st_q.s2 & ~st_q.s3);
endmodule

/* File: logic/itcf_top.sv */
// interrupt and trap control/status registers with first flag word, wishbone slave
// Functional notes
// - priority level is top bit over three low
// - top bit set exactly when level above seven
// - nesting off blocks preemption of running service
// - accumulator A and B overflow trap flags
// - accumulator A and B severe overflow flags
// - overflow traps only when own enable set
// - one enable gates both severe overflow traps
// - bad shift math trap sets its flag
// - divide by zero math trap sets flag
// - dma controller error trap sets flag
// - any math trap sets arithmetic fault flag
// - address, stack, oscillator trap flags kept
// - unimplemented bits always read zero
// - table select picks alternate vector table
// - read-only timed disable status bit
// - per-line polarity: 1 falling, 0 rising
// - flag reads one after source request
// - flag bits 14..8 mapped to sources
// - flag bits 7..0 mapped to sources
// - hardware sets flags, software clears them
// - nesting off makes low priority bits read-only
// - top bit set masks all user interrupts
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "itcf_params.svh"
module itcf_top (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire itcf_pkg::itcf_wb_req_t wb_req,
  output itcf_pkg::itcf_wb_rsp_t      wb_rsp,
  input  wire itcf_pkg::itcf_core_t   core_in,
  input  wire itcf_pkg::itcf_trap_evt_t trap_evt,
  input  wire logic [13:0]            periph_req,
  input  wire logic [4:0]             ext_line,
  output itcf_pkg::itcf_trap_req_t    trap_req,
  output logic [3:0]                  cpu_priority,
  output logic                        preempt_allowed,
  output logic                        user_irq_allowed,
  output logic                        vector_table_alt,
  output logic [4:0]                  ext_line_event,
  output logic [15:0]                 interrupt_flags_zero
);
  import itcf_pkg::*;

  typedef struct packed {
    logic           nesting_off;
    logic           acc_a_overflow_trap_en;
    logic           acc_b_overflow_trap_en;
    logic           severe_overflow_trap_en;
    logic           alternate_table_select;
    logic [4:0]     ext_polarity;
    logic [2:0]     priority_level_low_bits;
    logic           priority_level_top_bit;
    logic           preempt_ok;
    logic           user_ok;
    logic [4:0]     ext_evt;
    itcf_trap_req_t trap;
    itcf_wb_rsp_t   rsp;
  } itcf_state_t;

  itcf_state_t st_q;
  itcf_state_t st_d;

  logic [4:0]  edge_pulse;
  logic [15:0] trap_flags;
  logic [15:0] trap_set;
  logic [15:0] trap_wen;
  logic [15:0] flags0;
  logic [15:0] flags0_set;
  logic [15:0] flags0_wen;
  logic [15:0] lane_mask;
  logic        access;
  logic        wr;
  logic        hit;
  logic        ova;
  logic        ovb;
  logic        cova;
  logic        covb;
  logic        math;
  logic [15:0] ctl_one_rd;
  logic [15:0] ctl_two_rd;
  logic [15:0] status_rd;
  logic [15:0] core_rd;
  logic [15:0] rd_word;

  genvar gi;
  generate
    for (gi = 0; gi < `ITCF_EXT_LINES; gi++)
    begin : g_ext
      itcf_edge u_edge (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .line_i    (ext_line[gi]),
        .falling_i (st_q.ext_polarity[gi]),
        .pulse_o   (edge_pulse[gi])
      );
    end
  endgenerate

  // bus access decode; one wait state, answer registered
  assign access    = wb_req.cyc & wb_req.stb & ~st_q.rsp.ack;
  assign wr        = access & wb_req.we;
  assign lane_mask = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
  assign hit       = (wb_req.adr == `ITCF_OFS_CTL_ONE) | (wb_req.adr == `ITCF_OFS_CTL_TWO)
                   | (wb_req.adr == `ITCF_OFS_FLAGS_ZERO) | (wb_req.adr == `ITCF_OFS_STATUS_WORD)
                   | (wb_req.adr == `ITCF_OFS_CORE_WORD);

  // trap qualification by the enables
  assign ova  = trap_evt.acc_a_ovf & st_q.acc_a_overflow_trap_en;
  assign ovb  = trap_evt.acc_b_ovf & st_q.acc_b_overflow_trap_en;
  assign cova = trap_evt.acc_a_sev & st_q.severe_overflow_trap_en;
  assign covb = trap_evt.acc_b_sev & st_q.severe_overflow_trap_en;
  assign math = ova | ovb | cova | covb | trap_evt.bad_shift | trap_evt.zero_div;

  always_comb
  begin
    trap_set                       = `ITCF_RESET_WORD;
    trap_set[`ITCF_C1_ACC_A_OVF]   = ova;
    trap_set[`ITCF_C1_ACC_B_OVF]   = ovb;
    trap_set[`ITCF_C1_ACC_A_SEV]   = cova;
    trap_set[`ITCF_C1_ACC_B_SEV]   = covb;
    trap_set[`ITCF_C1_BAD_SHIFT]   = trap_evt.bad_shift;
    trap_set[`ITCF_C1_ZERO_DIV]    = trap_evt.zero_div;
    trap_set[`ITCF_C1_DMA_FAULT]   = trap_evt.dma_fault;
    trap_set[`ITCF_C1_ARITH_FAULT] = math;
    trap_set[`ITCF_C1_ADDR_FAULT]  = trap_evt.addr_fault;
    trap_set[`ITCF_C1_STACK_FAULT] = trap_evt.stack_fault;
    trap_set[`ITCF_C1_OSC_LOSS]    = trap_evt.osc_loss;
  end

  assign trap_wen   = (wr && wb_req.adr == `ITCF_OFS_CTL_ONE) ? (lane_mask & `ITCF_C1_FLAG_MASK) : 16'h0000;
  assign flags0_set = {1'b0, periph_req, edge_pulse[0]};
  assign flags0_wen = (wr && wb_req.adr == `ITCF_OFS_FLAGS_ZERO) ? (lane_mask & `ITCF_FLAGS_MASK) : 16'h0000;

  itcf_sticky #(
    .W (16)
  ) u_trap_flags (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .set_i    (trap_set),
    .wen_i    (trap_wen),
    .wdat_i   (wb_req.dat[15:0]),
    .q_o      (trap_flags)
  );

  itcf_sticky #(
    .W (16)
  ) u_flags0 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .set_i    (flags0_set),
    .wen_i    (flags0_wen),
    .wdat_i   (wb_req.dat[15:0]),
    .q_o      (flags0)
  );

  // read views; unimplemented positions forced to zero
  always_comb
  begin
    ctl_one_rd                       = trap_flags & `ITCF_C1_FLAG_MASK;
    ctl_one_rd[`ITCF_C1_NEST_OFF]    = st_q.nesting_off;
    ctl_one_rd[`ITCF_C1_OVA_TRAP_EN] = st_q.acc_a_overflow_trap_en;
    ctl_one_rd[`ITCF_C1_OVB_TRAP_EN] = st_q.acc_b_overflow_trap_en;
    ctl_one_rd[`ITCF_C1_SEV_TRAP_EN] = st_q.severe_overflow_trap_en;
    ctl_two_rd                       = `ITCF_RESET_WORD;
    ctl_two_rd[`ITCF_C2_ALT_TABLE]   = st_q.alternate_table_select;
    ctl_two_rd[`ITCF_C2_TIMED_DIS]   = core_in.timed_disable;
    ctl_two_rd[`ITCF_C2_POL_LSB +: `ITCF_EXT_LINES] = st_q.ext_polarity;
    status_rd                        = `ITCF_RESET_WORD;
    status_rd[`ITCF_SW_IPL_LSB +: 3] = st_q.priority_level_low_bits;
    core_rd                          = `ITCF_RESET_WORD;
    core_rd[`ITCF_CW_IPL_TOP]        = st_q.priority_level_top_bit;
    case (wb_req.adr)
      `ITCF_OFS_CTL_ONE:     rd_word = ctl_one_rd;
      `ITCF_OFS_CTL_TWO:     rd_word = ctl_two_rd;
      `ITCF_OFS_FLAGS_ZERO:  rd_word = flags0 & `ITCF_FLAGS_MASK;
      `ITCF_OFS_STATUS_WORD: rd_word = status_rd;
      `ITCF_OFS_CORE_WORD:   rd_word = core_rd;
      default:               rd_word = `ITCF_RESET_WORD;
    endcase
  end

  always_comb
  begin
    st_d = st_q;

    // control writes honour byte lanes
    if (wr && wb_req.adr == `ITCF_OFS_CTL_ONE)
    begin
      if (wb_req.sel[1])
      begin
        st_d.nesting_off             = wb_req.dat[`ITCF_C1_NEST_OFF];
        st_d.acc_a_overflow_trap_en  = wb_req.dat[`ITCF_C1_OVA_TRAP_EN];
        st_d.acc_b_overflow_trap_en  = wb_req.dat[`ITCF_C1_OVB_TRAP_EN];
        st_d.severe_overflow_trap_en = wb_req.dat[`ITCF_C1_SEV_TRAP_EN];
      end
    end
    if (wr && wb_req.adr == `ITCF_OFS_CTL_TWO)
    begin
      if (wb_req.sel[1])
        st_d.alternate_table_select = wb_req.dat[`ITCF_C2_ALT_TABLE];
      if (wb_req.sel[0])
        st_d.ext_polarity = wb_req.dat[`ITCF_C2_POL_LSB +: `ITCF_EXT_LINES];
    end

    // software may lower or raise the low bits unless nesting is off
    if (wr && wb_req.adr == `ITCF_OFS_STATUS_WORD && wb_req.sel[0] && !st_q.nesting_off)
      st_d.priority_level_low_bits = wb_req.dat[`ITCF_SW_IPL_LSB +: 3];
    // top bit is clear-only from software so traps stay unmaskable
    if (wr && wb_req.adr == `ITCF_OFS_CORE_WORD && wb_req.sel[0] && !wb_req.dat[`ITCF_CW_IPL_TOP])
      st_d.priority_level_top_bit = 1'b0;
    // the core's own level change wins over a software write
    if (core_in.ipl_load)
    begin
      st_d.priority_level_top_bit  = core_in.ipl_value[3];
      st_d.priority_level_low_bits = core_in.ipl_value[2:0];
    end

    st_d.preempt_ok = ~(st_d.nesting_off & core_in.in_service);
    st_d.user_ok    = ~st_d.priority_level_top_bit;

    st_d.trap.math  = math;
    st_d.trap.dma   = trap_evt.dma_fault;
    st_d.trap.addr  = trap_evt.addr_fault;
    st_d.trap.stack = trap_evt.stack_fault;
    st_d.trap.osc   = trap_evt.osc_loss;
    st_d.ext_evt    = edge_pulse;

    // unmapped addresses still answer, reading zero
    st_d.rsp.ack = access;
    if (access && !wb_req.we)
      st_d.rsp.dat = {16'h0000, hit ? rd_word : `ITCF_RESET_WORD};
    else
      st_d.rsp.dat = 32'h0000_0000;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q            <= '0;
      st_q.preempt_ok <= 1'b1;
      st_q.user_ok    <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign wb_rsp               = st_q.rsp;
  assign trap_req             = st_q.trap;
  assign cpu_priority         = {st_q.priority_level_top_bit, st_q.priority_level_low_bits};
  assign preempt_allowed      = st_q.preempt_ok;
  assign user_irq_allowed     = st_q.user_ok;
  assign vector_table_alt     = st_q.alternate_table_select;
  assign ext_line_event       = st_q.ext_evt;
  assign interrupt_flags_zero = flags0;
endmodule

/* File: testbench/itcf_top_props.sv */
// concurrent checks on the ports of the interrupt/trap flag block
`timescale 1ns/10ps
module itcf_top_props (
  input wire logic                     core_clk,
  input wire logic                     reset_n,
  input wire itcf_pkg::itcf_wb_req_t   wb_req,
  input wire itcf_pkg::itcf_wb_rsp_t   wb_rsp,
  input wire itcf_pkg::itcf_core_t     core_in,
  input wire itcf_pkg::itcf_trap_evt_t trap_evt,
  input wire logic [13:0]              periph_req,
  input wire logic [4:0]               ext_line,
  input wire itcf_pkg::itcf_trap_req_t trap_req,
  input wire logic [3:0]               cpu_priority,
  input wire logic                     preempt_allowed,
  input wire logic                     user_irq_allowed,
  input wire logic                     vector_table_alt,
  input wire logic [4:0]               ext_line_event,
  input wire logic [15:0]              interrupt_flags_zero
);
  import itcf_pkg::*;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  // reads above the last register land in no register
  sequence s_stray_read;
    s_take ##0 (!wb_req.we && wb_req.adr > 8'h10);
  endsequence
  chk_ack_next: assert property (s_take |=> wb_rsp.ack)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  chk_stray_zero: assert property (s_stray_read |=> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (wb_rsp.ack |-> wb_rsp.dat[31:16] == 16'h0 && !interrupt_flags_zero[15])
    else $error("unused bits not zero");
  chk_level_load: assert property (core_in.ipl_load |=> cpu_priority == $past(core_in.ipl_value))
    else $error("priority level not loaded");
  chk_top_masks: assert property (cpu_priority[3] |-> ##[0:1] !user_irq_allowed)
    else $error("user interrupts open with top bit set");
  chk_idle_preempt: assert property (!core_in.in_service |=> preempt_allowed)
    else $error("preemption blocked outside service");
  chk_math_trap: assert property (trap_evt.zero_div || trap_evt.bad_shift |=> trap_req.math)
    else $error("math trap missing");
  chk_dma_trap: assert property (trap_evt.dma_fault |=> trap_req.dma)
    else $error("dma trap missing");
  chk_sys_traps: assert property (trap_evt.osc_loss || trap_evt.addr_fault || trap_evt.stack_fault |=>
    trap_req.osc == $past(trap_evt.osc_loss) && trap_req.addr == $past(trap_evt.addr_fault)
    && trap_req.stack == $past(trap_evt.stack_fault))
    else $error("system trap missing");
  chk_flag_sets: assert property (|periph_req |=>
    (interrupt_flags_zero[14:1] & $past(periph_req)) == $past(periph_req))
    else $error("peripheral flag not set");
  chk_line_flag: assert property (ext_line_event[0] |=> interrupt_flags_zero[0])
    else $error("line zero flag not set");
  chk_edge_once: assert property (|ext_line_event |=> (ext_line_event & $past(ext_line_event)) == 5'h0)
    else $error("edge event longer than one cycle");
endmodule
bind itcf_top itcf_top_props chk_u (.core_clk, .reset_n, .wb_req, .wb_rsp, .core_in, .trap_evt, .periph_req,
  .ext_line, .trap_req, .cpu_priority, .preempt_allowed, .user_irq_allowed, .vector_table_alt, .ext_line_event,
  .interrupt_flags_zero);

/* File: testbench/itcf_src_model.sv */
// trap and peripheral request sources that fire after a chosen lag
`timescale 1ns/10ps
module itcf_src_model (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     fire,
  input  wire logic [3:0]               lag,
  input  wire itcf_pkg::itcf_trap_evt_t evt_cmd,
  input  wire logic [13:0]              per_cmd,
  output itcf_pkg::itcf_trap_evt_t      trap_evt,
  output logic [13:0]                   periph_req
);
  import itcf_pkg::*;
  logic [4:0]     cnt_q;
  itcf_trap_evt_t evt_q;
  logic [13:0]    per_q;
  // one-cycle pulses only: a held level would re-set a flag software cleared
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      cnt_q      <= 5'h00;
      evt_q      <= '0;
      per_q      <= '0;
      trap_evt   <= '0;
      periph_req <= '0;
    end
    else
    begin
      trap_evt   <= (cnt_q == 5'h01) ? evt_q : '0;
      periph_req <= (cnt_q == 5'h01) ? per_q : '0;
      if (fire)
      begin
        cnt_q <= {1'b0, lag} + 5'h01;
        evt_q <= evt_cmd;
        per_q <= per_cmd;
      end
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
    end
endmodule

/* File: testbench/test_interrupt_trap_control_flags.sv */
// self-checking bench for the interrupt/trap flag block
`timescale 1ns/10ps
`include "itcf_params.svh"
module test_interrupt_trap_control_flags;
  import itcf_pkg::*;
  logic           core_clk = 1'b0;
  logic           reset_n = 1'b0;
  itcf_wb_req_t   wb_req = '0;
  itcf_wb_rsp_t   wb_rsp;
  itcf_core_t     core_in = '0;
  itcf_trap_evt_t trap_evt;
  itcf_trap_evt_t evt_cmd = '0;
  itcf_trap_req_t trap_req;
  logic [13:0]    periph_req;
  logic [13:0]    per_cmd = '0;
  logic [4:0]     ext_line = '0;
  logic [4:0]     ext_line_event;
  logic [3:0]     cpu_priority;
  logic [3:0]     lag = '0;
  logic           preempt_allowed, user_irq_allowed, vector_table_alt;
  logic           fire = 1'b0;
  logic [15:0]    interrupt_flags_zero, rd;
  int             err_count = 0, checked = 0, ev_cnt = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
    ev_cnt <= ev_cnt + $countones(ext_line_event);
  itcf_top dut_u (.core_clk, .reset_n, .wb_req, .wb_rsp, .core_in, .trap_evt, .periph_req, .ext_line,
    .trap_req, .cpu_priority, .preempt_allowed, .user_irq_allowed, .vector_table_alt, .ext_line_event,
    .interrupt_flags_zero);
  itcf_src_model src_u (.core_clk, .reset_n, .fire, .lag, .evt_cmd, .per_cmd, .trap_evt, .periph_req);
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after an edge; leaves one idle cycle behind it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h3, {16'h0, dat}};
    do @(posedge core_clk);
    while (wb_rsp.ack !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      err_count++;
      close_out;
    end
    rd = wb_rsp.dat[15:0];
    wb_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic go(input itcf_trap_evt_t e, input logic [13:0] p);
    lag <= 4'($urandom);
    evt_cmd <= e;
    per_cmd <= p;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (24) @(posedge core_clk);
  endtask
  function automatic logic [15:0] exp_c1(input itcf_trap_evt_t e, input logic [2:0] en);
    logic [3:0] ov;
    ov = {e.acc_a_ovf & en[2], e.acc_b_ovf & en[1], e.acc_a_sev & en[0], e.acc_b_sev & en[0]};
    return {1'b0, ov, en, e.bad_shift, e.zero_div, e.dma_fault, |ov | e.bad_shift | e.zero_div,
            e.addr_fault, e.stack_fault, e.osc_loss, 1'b0};
  endfunction
  initial
  begin
    itcf_trap_evt_t e;
    logic [2:0]     en;
    logic [13:0]    p;
    logic           pol;
    int             n0;
    n0 = $urandom(32'h170b7c2d);
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 6; a++)
    begin
      wb(1'b0, 8'(a * 4), 16'h0);
      chk(rd, 16'h0000);
    end
    chk({13'h0, preempt_allowed, user_irq_allowed, vector_table_alt}, 16'h0006);
    $display("reset values done");
    wb(1'b1, `ITCF_OFS_CTL_ONE, 16'hffff);
    wb(1'b0, `ITCF_OFS_CTL_ONE, 16'h0);
    chk(rd, 16'hfffe);
    wb(1'b1, `ITCF_OFS_FLAGS_ZERO, 16'hffff);
    wb(1'b0, `ITCF_OFS_FLAGS_ZERO, 16'h0);
    chk(rd, 16'h7fff);
    core_in.timed_disable <= 1'b1;
    core_in.in_service <= 1'b1;
    wb(1'b1, `ITCF_OFS_CTL_TWO, 16'hffff);
    wb(1'b0, `ITCF_OFS_CTL_TWO, 16'h0);
    chk(rd, 16'hc01f);
    chk({15'h0, vector_table_alt}, 16'h1);
    wb(1'b1, `ITCF_OFS_STATUS_WORD, 16'h00e0);
    wb(1'b0, `ITCF_OFS_STATUS_WORD, 16'h0);
    chk(rd, 16'h0000);
    chk({15'h0, preempt_allowed}, 16'h0);
    wb(1'b1, `ITCF_OFS_CTL_ONE, 16'h0);
    chk({15'h0, preempt_allowed}, 16'h1);
    core_in.timed_disable <= 1'b0;
    core_in.in_service <= 1'b0;
    wb(1'b1, `ITCF_OFS_CTL_TWO, 16'h0);
    chk({15'h0, vector_table_alt}, 16'h0);
    $display("control registers done");
    for (int v = 0; v < 16; v++)
    begin
      core_in.ipl_load <= 1'b1;
      core_in.ipl_value <= 4'(v);
      @(posedge core_clk);
      core_in.ipl_load <= 1'b0;
      wb(1'b0, `ITCF_OFS_STATUS_WORD, 16'h0);
      chk(rd, {8'h0, 3'(v), 5'h0});
      wb(1'b0, `ITCF_OFS_CORE_WORD, 16'h0);
      chk(rd, {12'h0, v > 7, 3'h0});
      chk({14'h0, cpu_priority[3], user_irq_allowed}, {14'h0, v > 7, v < 8});
    end
    wb(1'b1, `ITCF_OFS_CORE_WORD, 16'h0);
    chk({12'h0, cpu_priority}, 16'h0007);
    // software may only clear the top bit, so traps stay unmaskable
    wb(1'b1, `ITCF_OFS_CORE_WORD, 16'h0008);
    chk({12'h0, cpu_priority}, 16'h0007);
    $display("priority level done");
    for (int i = 0; i < 12; i++)
    begin
      e = (i < 2) ? '1 : itcf_trap_evt_t'(10'($urandom));
      en = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
      p = (i == 0) ? 14'h3fff : 14'($urandom);
      wb(1'b1, `ITCF_OFS_CTL_ONE, {5'h0, en, 8'h0});
      wb(1'b1, `ITCF_OFS_FLAGS_ZERO, 16'h0);
      go(e, p);
      wb(1'b0, `ITCF_OFS_CTL_ONE, 16'h0);
      chk(rd, exp_c1(e, en));
      wb(1'b0, `ITCF_OFS_FLAGS_ZERO, 16'h0);
      chk(rd, {1'b0, p, 1'b0});
    end
    // corner: software clear lands on the very edge the set pulse is taken
    lag <= 4'h0;
    per_cmd <= 14'h2aaa;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
    wb(1'b1, `ITCF_OFS_FLAGS_ZERO, 16'h0);
    wb(1'b0, `ITCF_OFS_FLAGS_ZERO, 16'h0);
    chk(rd, 16'h5554);
    wb(1'b1, `ITCF_OFS_FLAGS_ZERO, 16'h0);
    chk(interrupt_flags_zero, 16'h0);
    $display("traps and flags done");
    for (int k = 0; k < 5; k++)
    begin
      pol = 1'($urandom);
      wb(1'b1, `ITCF_OFS_CTL_TWO, 16'(pol) << k);
      ext_line[k] <= pol;
      repeat (6) @(posedge core_clk);
      n0 = ev_cnt;
      ext_line[k] <= !pol;
      repeat (6) @(posedge core_clk);
      ext_line[k] <= pol;
      repeat (6) @(posedge core_clk);
      chk(16'(ev_cnt - n0), 16'h1);
    end
    wb(1'b0, `ITCF_OFS_FLAGS_ZERO, 16'h0);
    chk(rd, 16'h0001);
    $display("external lines done");
    close_out;
  end
  // whole run is under a thousand cycles; the limit is ten thousand
  initial
  begin
    #500us;
    err_count++;
    close_out;
  end
endmodule
